// >>> pkg/batt_ctrl_params.svh
`ifndef BATT_CTRL_PARAMS_SVH
`define BATT_CTRL_PARAMS_SVH
// Register offsets (word addresses on the plain register port)
`define OFS_SYS_STATE    8'h00
`define OFS_IRQ_STATUS   8'h01
`define OFS_IRQ_MASK     8'h02
`define OFS_BATT_INPUTS  8'h03
// Control register field positions
`define FLD_CAL_ACTIVE   0
`define FLD_CAL_BAT1     1
`define FLD_CAL_BAT2     2
`define FLD_CHG_BLOCK    3
`define FLD_CAL_REQ      4
`define FLD_MODE_LO      5
// Interrupt status field positions
`define IRQ_CAL_END      0
`define IRQ_CAL_HANDOFF  1
`define IRQ_MODE_CHG     2
`define IRQ_CHG_START    3
// Reset values
`define RST_SYS_STATE    8'h00
`define RST_IRQ_MASK     4'h0
// Timing, 40 MHz reference clock, 25 ns period
`define CLK_PERIOD_NS    25
`define DROPOUT_ON_NS    200
`define DROPOUT_PER_NS   40000
// Least time rounds up, longest rounds down
`define DROPOUT_ON_CYC   ((`DROPOUT_ON_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DROPOUT_PER_CYC  (`DROPOUT_PER_NS / `CLK_PERIOD_NS)
`endif

// >>> pkg/batt_ctrl_pkg.sv
package batt_ctrl_pkg;
    // Operating mode decoded from strap and host-bus supply
    typedef enum logic [3:0] {
        MODE_STANDALONE = 4'b0001,
        MODE_INHIBIT    = 4'b0010,
        MODE_NO_HOST    = 4'b0100,
        MODE_HOST       = 4'b1000
    } op_mode_t;
    // Calibration sequencer states
    typedef enum logic [2:0] {
        CAL_IDLE   = 3'b001,
        CAL_RUN    = 3'b010,
        CAL_CHARGE = 3'b100
    } cal_state_t;
    typedef logic [7:0] reg_addr_t;
    typedef logic [7:0] reg_data_t;
endpackage

// >>> design/status_blinker.sv
// One standalone status indicator: low while charging, high when adapter or battery absent,
// toggling on each blink tick once charge has completed.
module status_blinker (
    input  wire logic ref_clk,      // System clock
    input  wire logic rst_b,        // Synchronous reset, active low
    input  wire logic adapter_ok,   // Adapter present
    input  wire logic batt_ok,      // Battery present
    input  wire logic charging,     // Battery being charged
    input  wire logic blink_tick,   // One-cycle pulse per blink edge
    output logic      status_out    // Indicator level
);
    logic blink_ff; // Blink phase

    // Blink phase toggles on each sampled rising edge of the rate input
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            blink_ff <= 1'b1;
        end else if (blink_tick) begin
            blink_ff <= ~blink_ff;
        end
    end

    // Indicator level from charge state
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            status_out <= 1'b1;
        end else if (!adapter_ok || !batt_ok) begin
            status_out <= 1'b1;
        end else if (charging) begin
            status_out <= 1'b0;
        end else begin
            status_out <= blink_ff;
        end
    end
endmodule

// >>> design/batt_mode_ctrl.sv
// Operation
// - Clear calibration on removal, fault, alarm, write
// - Removed calibrated battery hands over to other
// - Start charge after calibration discharge ends
// - Discharge while calibrating; freeze cached request
// - Standalone mode repurposes host bus pins
// - Status low charging, high absent, blinking done
// - Clock pin sets blink rate; high stops
// - Strap low, supply high: inhibit charging
// - Inhibit reads as charge-block bit one
// - Strap high, supply low: ignore host pins
// - Strap high, supply high: host mode, charge
// - Dropout forces bottom switch 200ns per 40us
// - Overvoltage holds top switch off
// - Charger disabled holds mux switches off
// - Controlled charge needs minimum voltage; wake-up exempt
`include "batt_ctrl_params.svh"
module batt_mode_ctrl (
    input  wire logic                  ref_clk,           // 40 MHz clock
    input  wire logic                  rst_b,             // Sync reset, active low
    input  wire batt_ctrl_pkg::reg_addr_t reg_addr,       // Register address
    input  wire batt_ctrl_pkg::reg_data_t reg_wdata,      // Write data
    input  wire logic                  reg_wr,            // Write strobe
    input  wire logic                  reg_rd,            // Read strobe
    output batt_ctrl_pkg::reg_data_t   reg_rdata,         // Read data, cycle after
    output logic                       irq,               // Level interrupt
    input  wire logic                  mode_strap,        // Strap: 1 local supply, 0 ground
    input  wire logic                  host_bus_supply_sense, // Host supply high
    input  wire logic                  adapter_present,   // Adapter present
    input  wire logic [1:0]            batt_present,      // Battery presence
    input  wire logic [1:0]            cond_request,      // Conditioning request
    input  wire logic [1:0]            stop_discharge_alarm, // Battery alarm
    input  wire logic [1:0]            fully_discharged,  // Battery alarm
    input  wire logic                  supply_fault,      // Power not good
    input  wire logic [1:0]            above_min_charge_voltage, // Above min_charge_voltage
    input  wire logic [1:0]            charge_want,       // Charger algorithm asks
    input  wire logic                  wakeup_charge,     // Wake-up charging
    input  wire logic                  dropout_detect,    // Top switch stuck on
    input  wire logic                  over_voltage,      // Output overshoot
    input  wire logic                  top_req,           // Loop requests top on
    input  wire logic                  scl_in,            // Host clock pin in
    input  wire logic                  sda_in,            // Host data pin in
    output logic                       sda_out,           // Data pin drive level
    output logic                       sda_oe,            // Data pin drive enable
    output logic                       alert_out,         // Alert pin drive level
    output logic                       alert_oe,          // Alert pin drive enable
    input  wire logic                  host_alert,        // Normal alert request
    output logic                       host_bus_en,       // Host pins carry traffic
    output logic [1:0]                 discharge_sel,     // Battery discharging
    output logic [1:0]                 mux_on,            // Charge mux switch enable
    output logic                       charger_en,        // Charger running
    output logic                       top_gate,          // Top switch drive
    output logic                       bot_gate,          // Bottom switch drive
    output logic                       charge_start       // Charge cycle attempt pulse
);
    import batt_ctrl_pkg::*;

    // Synchronisers, two flops each
    logic [8:0] sync1_ff;   // First stage
    logic [8:0] sync2_ff;   // Second stage
    logic       scl_d_ff;   // Previous synced blink input
    logic       strap_s, hsup_s, ac_s, fault_s, scl_s;
    logic [1:0] pres_s;
    logic [1:0] req_s;

    // Control state
    op_mode_t   mode_ff, nxt_mode;   // Decoded mode
    cal_state_t cal_ff;              // Calibration sequencer
    logic [1:0] cal_sel_ff;          // Battery under calibration
    logic [1:0] host_pick_ff;        // Host choice of battery
    logic [1:0] req_cache_ff;        // Cached conditioning request
    logic [3:0] irq_stat_ff;         // Sticky events
    logic [3:0] irq_mask_ff;         // Event mask
    logic [3:0] irq_evt;             // Events this cycle
    logic       cal_end, handoff;    // Calibration end and handover
    logic       cal_wr_set, cal_wr_clr;
    logic       chg_ok;              // Charging allowed by mode
    logic [15:0] drop_cnt_ff;        // Dropout interval counter
    logic        drop_fire;          // Bottom switch refresh window
    logic [1:0]  stat_b;             // Standalone indicator levels

    // Register write decode, used for several registers
    function automatic logic hit(input reg_addr_t a, input reg_addr_t ofs);
        hit = (a == ofs);
    endfunction

    // Two-flop synchronisers for strap, host supply, adapter, fault, presence, request and clock pin inputs
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            // Clock pin bit starts at its idle high, so no false blink edge
            sync1_ff <= 9'h100;
            sync2_ff <= 9'h100;
        end else begin
            sync1_ff <= {scl_in, cond_request, batt_present, supply_fault,
                         adapter_present, host_bus_supply_sense, mode_strap};
            sync2_ff <= sync1_ff;
        end
    end
    assign strap_s = sync2_ff[0];
    assign hsup_s  = sync2_ff[1];
    assign ac_s    = sync2_ff[2];
    assign fault_s = sync2_ff[3];
    assign pres_s  = sync2_ff[5:4];
    assign req_s   = sync2_ff[7:6];
    assign scl_s   = sync2_ff[8];

    // Mode decode from strap and host-bus supply
    always_comb begin
        case ({strap_s, hsup_s})
            2'b00:   nxt_mode = MODE_STANDALONE;
            2'b01:   nxt_mode = MODE_INHIBIT;
            2'b10:   nxt_mode = MODE_NO_HOST;
            default: nxt_mode = MODE_HOST;
        endcase
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            mode_ff <= MODE_HOST;
        end else begin
            mode_ff <= nxt_mode;
        end
    end
    assign chg_ok = (mode_ff != MODE_INHIBIT);

    // Pin function per mode
    always_comb begin
        host_bus_en = 1'b0;
        sda_out     = 1'b0;
        sda_oe      = 1'b0;
        alert_out   = 1'b0;
        alert_oe    = 1'b0;
        case (mode_ff)
            MODE_STANDALONE: begin
                sda_out   = stat_b[1];
                sda_oe    = 1'b1;
                alert_out = stat_b[0];
                alert_oe  = 1'b1;
            end
            MODE_NO_HOST: begin
                alert_oe  = host_alert;
            end
            MODE_INHIBIT, MODE_HOST: begin
                host_bus_en = 1'b1;
                alert_oe    = host_alert;
            end
            default: begin
                host_bus_en = 1'b0;
            end
        endcase
    end

    // Blink ticks from synchronised clock pin edges
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            scl_d_ff <= 1'b1;
        end else begin
            scl_d_ff <= scl_s;
        end
    end

    // Indicators, one per battery
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_stat
            status_blinker u_blink (
                .ref_clk    (ref_clk),
                .rst_b      (rst_b),
                .adapter_ok (ac_s),
                .batt_ok    (pres_s[gi]),
                .charging   (mux_on[gi]),
                .blink_tick (scl_s & ~scl_d_ff),
                .status_out (stat_b[gi])
            );
        end
    endgenerate

    // Conditioning request cache, frozen while calibrating
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            req_cache_ff <= 2'b00;
        end else if (cal_ff != CAL_RUN) begin
            req_cache_ff <= req_s;
        end
    end

    // Software calibration writes
    assign cal_wr_set = reg_wr && hit(reg_addr, `OFS_SYS_STATE) && reg_wdata[`FLD_CAL_ACTIVE];
    assign cal_wr_clr = reg_wr && hit(reg_addr, `OFS_SYS_STATE) && !reg_wdata[`FLD_CAL_ACTIVE];

    // Host choice of battery, locked during calibration
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            host_pick_ff <= 2'b00;
        end else if (reg_wr && hit(reg_addr, `OFS_SYS_STATE) && cal_ff != CAL_RUN) begin
            host_pick_ff <= reg_wdata[`FLD_CAL_BAT2:`FLD_CAL_BAT1];
        end
    end

    // End conditions for the battery under calibration
    assign cal_end = (cal_ff == CAL_RUN) &&
                     (!ac_s || fault_s || cal_wr_clr ||
                      |(cal_sel_ff & ~pres_s) ||
                      |(cal_sel_ff & (stop_discharge_alarm | fully_discharged)));
    assign handoff = cal_end && ac_s && !fault_s && !cal_wr_clr &&
                     |(cal_sel_ff & ~pres_s) &&
                     |(~cal_sel_ff & req_cache_ff & pres_s);

    // Calibration sequencer
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            cal_ff     <= CAL_IDLE;
            cal_sel_ff <= 2'b00;
        end else begin
            case (cal_ff)
                CAL_IDLE: begin
                    if (cal_wr_set && ac_s && |req_cache_ff) begin
                        cal_ff <= CAL_RUN;
                        if (host_pick_ff != 2'b00) begin
                            cal_sel_ff <= host_pick_ff & req_cache_ff;
                        end else if (req_cache_ff[0]) begin
                            cal_sel_ff <= 2'b01;
                        end else begin
                            cal_sel_ff <= 2'b10;
                        end
                    end
                end
                CAL_RUN: begin
                    if (handoff) begin
                        cal_sel_ff <= ~cal_sel_ff;
                    end else if (cal_end) begin
                        cal_ff     <= CAL_CHARGE;
                        cal_sel_ff <= 2'b00;
                    end
                end
                CAL_CHARGE: begin
                    cal_ff <= CAL_IDLE;
                end
                default: begin
                    cal_ff <= CAL_IDLE;
                end
            endcase
        end
    end
    assign discharge_sel = (cal_ff == CAL_RUN) ? cal_sel_ff : 2'b00;
    assign charge_start  = (cal_ff == CAL_CHARGE);

    // Charge gating
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            charger_en <= 1'b0;
        end else begin
            charger_en <= chg_ok && ac_s && !fault_s && (cal_ff != CAL_RUN) && |charge_want;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            mux_on <= 2'b00;
        end else if (!charger_en) begin
            mux_on <= 2'b00;
        end else begin
            mux_on <= charge_want & pres_s &
                      (wakeup_charge ? 2'b11 : above_min_charge_voltage);
        end
    end

    // Dropout refresh timer
    always_ff @(posedge ref_clk) begin
        if (!rst_b || !dropout_detect) begin
            drop_cnt_ff <= 16'h0000;
        end else if (drop_cnt_ff == 16'(`DROPOUT_PER_CYC - 1)) begin
            drop_cnt_ff <= 16'h0000;
        end else begin
            drop_cnt_ff <= drop_cnt_ff + 16'h0001;
        end
    end
    assign drop_fire = dropout_detect && (drop_cnt_ff >= 16'(`DROPOUT_PER_CYC - `DROPOUT_ON_CYC));
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            top_gate <= 1'b0;
            bot_gate <= 1'b0;
        end else begin
            top_gate <= charger_en && top_req && !over_voltage && !drop_fire;
            bot_gate <= charger_en && (!top_req || drop_fire) && !over_voltage;
        end
    end

    // Interrupt events, sticky with write-one-to-clear; set beats clear
    assign irq_evt = {charge_start, (nxt_mode != mode_ff), handoff, cal_end};
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            irq_stat_ff <= 4'h0;
        end else if (reg_wr && hit(reg_addr, `OFS_IRQ_STATUS)) begin
            irq_stat_ff <= (irq_stat_ff & ~reg_wdata[3:0]) | irq_evt;
        end else begin
            irq_stat_ff <= irq_stat_ff | irq_evt;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            irq_mask_ff <= `RST_IRQ_MASK;
        end else if (reg_wr && hit(reg_addr, `OFS_IRQ_MASK)) begin
            irq_mask_ff <= reg_wdata[3:0];
        end
    end
    assign irq = |(irq_stat_ff & irq_mask_ff);

    // Read data, registered one cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            reg_rdata <= `RST_SYS_STATE;
        end else if (reg_rd) begin
            case (reg_addr)
                `OFS_SYS_STATE:   reg_rdata <= {mode_ff[2:0], req_cache_ff[0] | req_cache_ff[1],
                                                !chg_ok, cal_sel_ff | host_pick_ff,
                                                cal_ff == CAL_RUN};
                `OFS_IRQ_STATUS:  reg_rdata <= {4'h0, irq_stat_ff};
                `OFS_IRQ_MASK:    reg_rdata <= {4'h0, irq_mask_ff};
                `OFS_BATT_INPUTS: reg_rdata <= {2'b00, req_cache_ff, pres_s, fault_s, ac_s};
                default:          reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule

// >>> dv/host_side_model.sv
// Host-side party: drives the blink-rate clock pin
module host_side_model (
    input  wire logic ref_clk,  // Bench clock
    input  wire logic blink_on, // Blinking wanted
    output logic      scl_in    // Blink-rate clock pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] cnt_ff; // Half-period counter
    initial scl_in = 1'b1;
    initial cnt_ff = 5'h00;
    // Toggle every 20 cycles while blinking, else hold the pin high
    always @(posedge ref_clk) begin
        if (!blink_on) begin
            scl_in <= 1'b1;
            cnt_ff <= 5'h00;
        end else if (cnt_ff == 5'h13) begin
            scl_in <= !scl_in;
            cnt_ff <= 5'h00;
        end else begin
            cnt_ff <= cnt_ff + 5'h01;
        end
    end
endmodule

// >>> dv/batt_mode_ctrl_asserts.sv
// Port-level checks on the mode and charge control block
module batt_mode_ctrl_asserts
    import batt_ctrl_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       rst_b,
    input wire logic       reg_rd,
    input wire reg_data_t  reg_rdata,
    input wire logic       mode_strap,
    input wire logic       host_bus_supply_sense,
    input wire logic [1:0] stop_discharge_alarm,
    input wire logic [1:0] above_min_charge_voltage,
    input wire logic       wakeup_charge,
    input wire logic       dropout_detect,
    input wire logic       over_voltage,
    input wire logic       top_req,
    input wire logic       sda_oe,
    input wire logic       host_bus_en,
    input wire logic [1:0] discharge_sel,
    input wire logic [1:0] mux_on,
    input wire logic       charger_en,
    input wire logic       top_gate,
    input wire logic       bot_gate,
    input wire logic       charge_start
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dcb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read");
    AST_STANDALONE: assert property (
        (!mode_strap && !host_bus_supply_sense)[*6] |-> !host_bus_en)
        else $error("host pins not repurposed");
    AST_INHIBIT: assert property (
        (!mode_strap && host_bus_supply_sense)[*6] |=> !charger_en && mux_on == 2'b00)
        else $error("charging while inhibited");
    AST_NO_HOST: assert property (
        (mode_strap && !host_bus_supply_sense)[*6] |-> !host_bus_en && !sda_oe)
        else $error("host pins used without host");
    AST_HOST: assert property (
        (mode_strap && host_bus_supply_sense)[*6] |-> host_bus_en)
        else $error("host pins idle in host mode");
    AST_CAL_ALARM: assert property (
        $rose(stop_discharge_alarm[0]) && discharge_sel == 2'b01
        |-> ##[1:3] discharge_sel == 2'b00)
        else $error("calibration kept after alarm");
    AST_CAL_END: assert property ($fell(|discharge_sel) |-> ##[0:3] charge_start)
        else $error("no charge attempt after calibration");
    AST_DROP_PULSE: assert property (
        $rose(bot_gate) && dropout_detect && top_req |-> bot_gate[*8] ##1 !bot_gate)
        else $error("dropout pulse length wrong");
    AST_GATES_EXCL: assert property (!(top_gate && bot_gate))
        else $error("both switches on");
    AST_OV_TOP: assert property (over_voltage |=> !top_gate)
        else $error("top switch on in overvoltage");
    AST_MUX_OFF: assert property (
        !charger_en && !$past(charger_en) |-> mux_on == 2'b00)
        else $error("mux on with charger off");
    AST_MIN_V: assert property (
        !$past(wakeup_charge) |-> (mux_on & ~$past(above_min_charge_voltage)) == 2'b00)
        else $error("charge below minimum voltage");
endmodule
bind batt_mode_ctrl batt_mode_ctrl_asserts u_batt_mode_ctrl_asserts (.*);

// >>> dv/tb_batt_mode_ctrl.sv
module tb_batt_mode_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import batt_ctrl_pkg::*;
    typedef struct {logic strap; logic sup; reg_data_t sys; logic hbe;} mode_row_t;
    // Mode table: strap, host supply, state register, host pins in use
    mode_row_t rows [4] = '{'{1'b0, 1'b0, 8'h20, 1'b0}, '{1'b0, 1'b1, 8'h48, 1'b1},
                            '{1'b1, 1'b0, 8'h80, 1'b0}, '{1'b1, 1'b1, 8'h00, 1'b1}};
    logic ref_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, irq;
    reg_addr_t reg_addr = 8'h00;
    reg_data_t reg_wdata = 8'h00, reg_rdata, rv;
    logic mode_strap = 1'b1, host_bus_supply_sense = 1'b1, adapter_present = 1'b0;
    logic [1:0] batt_present = 2'b00, cond_request = 2'b00, stop_discharge_alarm = 2'b00;
    logic [1:0] fully_discharged = 2'b00, above_min_charge_voltage = 2'b00;
    logic [1:0] charge_want = 2'b00, discharge_sel, mux_on;
    logic supply_fault = 1'b0, wakeup_charge = 1'b0, dropout_detect = 1'b0;
    logic over_voltage = 1'b0, top_req = 1'b0, scl_in, sda_in = 1'b1, host_alert = 1'b0;
    logic sda_out, sda_oe, alert_out, alert_oe, host_bus_en, charger_en;
    logic top_gate, bot_gate, charge_start, blink_on = 1'b0, scl_q, sda_q, al_q;
    int checks = 0, bad_count = 0, cycles = 0, rises = 0, tg_sda = 0, tg_al = 0;
    int starts = 0, n, m, r0, t0, a0;
    // Pin levels with pull-ups where released
    wire sda_lvl = sda_oe ? sda_out : 1'b1;
    wire al_lvl = alert_oe ? alert_out : 1'b1;
    batt_mode_ctrl u_batt_mode_ctrl (.*);
    host_side_model u_host_side_model (.ref_clk(ref_clk), .blink_on(blink_on), .scl_in(scl_in));
    always #12.5 ref_clk = !ref_clk;
    // Edge and pulse counters, sampled away from the launching edge
    always @(negedge ref_clk) begin
        if (scl_in && !scl_q) rises++;
        if (sda_lvl !== sda_q) tg_sda++;
        if (al_lvl !== al_q) tg_al++;
        if (charge_start === 1'b1) starts++;
        scl_q = scl_in;
        sda_q = sda_lvl;
        al_q = al_lvl;
    end
    // Hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic cmp(string s, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", s, e, g);
        end
    endtask
    task automatic cyc(int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    task automatic wreg(reg_addr_t a, reg_data_t d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rreg(reg_addr_t a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    task automatic start_cal(logic [1:0] req);
        @(posedge ref_clk);
        cond_request <= req;
        cyc(6);
        wreg(8'h00, 8'h01);
        cyc(3);
    endtask
    // Apply or withdraw one calibration end cause
    task automatic cause(int i, logic v);
        @(posedge ref_clk);
        case (i)
            0: adapter_present <= !v;
            1: supply_fault <= v;
            2: stop_discharge_alarm <= {1'b0, v};
            3: fully_discharged <= {1'b0, v};
            default: if (v) wreg(8'h00, 8'h00);
        endcase
    endtask
    // Cycles until the bottom switch reaches the given level
    task automatic run_len(logic lv, output int k);
        k = 0;
        while (bot_gate !== lv && k < 4000) begin
            cyc(1);
            k++;
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        cyc(2);
        cmp("rdata in reset", 8'h00, reg_rdata);
        cmp("irq in reset", 1'b0, irq);
        cmp("host pins in reset", 1'b1, host_bus_en);
        @(posedge ref_clk);
        rst_b <= 1'b1;
        rreg(8'h02);
        cmp("mask reset", 8'h00, rv);
        rreg(8'h10);
        cmp("unmapped read", 8'h00, rv);
        $display("reset test done");
        foreach (rows[i]) begin
            @(posedge ref_clk);
            mode_strap <= rows[i].strap;
            host_bus_supply_sense <= rows[i].sup;
            cyc(8);
            cmp("host pins", rows[i].hbe, host_bus_en);
            rreg(8'h00);
            cmp("state reg", rows[i].sys, rv);
        end
        $display("mode table done");
        adapter_present <= 1'b1;
        batt_present <= 2'b11;
        wreg(8'h02, 8'h01);
        for (int i = 0; i < 5; i++) begin
            n = starts;
            start_cal(2'b01);
            cmp("cal pick", 2'b01, discharge_sel);
            cond_request <= 2'b00;
            cyc(6);
            cmp("cal frozen", 2'b01, discharge_sel);
            rreg(8'h03);
            cmp("request frozen", 2'b01, rv[5:4]);
            cause(i, 1'b1);
            cyc(6);
            cmp("cal cleared", 2'b00, discharge_sel);
            cmp("charge attempt", n + 1, starts);
            cmp("irq raised", 1'b1, irq);
            wreg(8'h01, 8'h01);
            cyc(1);
            cmp("irq cleared", 1'b0, irq);
            cause(i, 1'b0);
        end
        wreg(8'h02, 8'h08);
        cyc(1);
        cmp("irq unmasked", 1'b1, irq);
        wreg(8'h02, 8'h00);
        cyc(1);
        cmp("irq masked", 1'b0, irq);
        start_cal(2'b11);
        cmp("cal both", 2'b01, discharge_sel);
        batt_present <= 2'b10;
        cyc(6);
        cmp("cal handoff", 2'b10, discharge_sel);
        wreg(8'h00, 8'h00);
        batt_present <= 2'b11;
        $display("calibration test done");
        charge_want <= 2'b01;
        above_min_charge_voltage <= 2'b11;
        top_req <= 1'b1;
        dropout_detect <= 1'b1;
        run_len(1'b1, n);
        run_len(1'b0, n);
        run_len(1'b1, m);
        cmp("dropout on", 200 / 25, n);
        cmp("dropout period", 40000 / 25, n + m);
        // Let the refresh pulse finish before the overshoot
        cyc(10);
        over_voltage <= 1'b1;
        cyc(2);
        cmp("top off on overvoltage", 1'b0, top_gate);
        over_voltage <= 1'b0;
        $display("charger test done");
        top_req <= 1'b0;
        dropout_detect <= 1'b0;
        charge_want <= 2'b00;
        mode_strap <= 1'b0;
        host_bus_supply_sense <= 1'b0;
        cyc(10);
        {r0, t0, a0} = {rises, tg_sda, tg_al};
        blink_on <= 1'b1;
        cyc(400);
        blink_on <= 1'b0;
        cyc(20);
        cmp("bat2 blinks", rises - r0, tg_sda - t0);
        cmp("bat1 blinks", rises - r0, tg_al - a0);
        t0 = tg_sda;
        cyc(60);
        cmp("steady with clock high", t0, tg_sda);
        charge_want <= 2'b11;
        cyc(12);
        cmp("charging", 2'b00, {sda_lvl, al_lvl});
        above_min_charge_voltage <= 2'b01;
        cyc(2);
        cmp("below minimum", 2'b01, mux_on);
        wakeup_charge <= 1'b1;
        cyc(2);
        cmp("wake-up charge", 2'b11, mux_on);
        adapter_present <= 1'b0;
        cyc(10);
        cmp("no adapter", 2'b11, {sda_lvl, al_lvl});
        cmp("mux off", 2'b00, mux_on);
        $display("indicator test done");
        end_of_test();
    end
endmodule
